// ---- pkg/gbe_pcs_map.svh ----
`ifndef GBE_PCS_MAP_SVH
`define GBE_PCS_MAP_SVH

// Transmit path stage latencies, in cycles
`define TX_FSM_LAT 3
`define TX_RA_LAT_CLASSIC 9
`define TX_RA_LAT_GATED 2

// Receive path fixed stage latencies, in cycles
`define RX_FSM_LAT 6
`define RX_RA_LAT_CLASSIC 8
`define RX_RA_LAT_GATED 2

// Clock tolerance buffer latency, nominal and spread, in cycles
`define CTF_NOM_LAT 27
`define CTF_MIN_LAT 24
`define CTF_MAX_LAT 34

// Clock tolerance buffer thresholds and slip limits
`define CTF_LOW_THR 16
`define CTF_HIGH_THR 32
`define CTF_SLIP_STEP 2
`define CTF_SLIP_MAX 4
`define CTF_DEPTH 64

// Reference conditions under which the latencies hold
`define MEAS_CLK_MHZ 125
`define MEAS_IFG_CYCLES 12

`endif

// ---- pkg/gbe_pcs_pkg.sv ----
`default_nettype none
package gbe_pcs_pkg;

  // Style of the MAC-facing interface
  typedef enum logic {
    GMII_CLASSIC = 1'b0,
    GMII_GATED   = 1'b1
  } gmii_style_t;

  // Clock tolerance buffer read-side states
  typedef enum logic [2:0] {
    CTF_FILL = 3'b001,
    CTF_RUN  = 3'b010,
    CTF_ADD  = 3'b100
  } ctf_state_t;

endpackage
`default_nettype wire

// ---- hdl/clock_tolerance_ram.sv ----
`timescale 1ns/1ns
`default_nettype none

module clock_tolerance_ram #(
  parameter int WIDTH = 10,
  parameter int AW    = 6
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             sys_rst,
  // Write port
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_addr,
  input  wire logic [WIDTH-1:0] wr_data,
  // Read port, data registered
  input  wire logic             rd_en,
  input  wire logic [AW-1:0]    rd_addr,
  output logic      [WIDTH-1:0] rd_data
);

  logic [WIDTH-1:0] mem [2**AW];

  // Storage has no reset so it can map to block memory
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Read data held until the next read
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_data <= '0;
    end else if (rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule

`default_nettype wire

// ---- hdl/gbe_pcs_status_latency.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "gbe_pcs_map.svh"
// Behaviour
// - Collision output is transmit enable ANDed with receive data valid.
// - Carrier sense output equals receive data valid with nothing else mixed in.
// - Transmit latency is fixed at 3 plus 9 (classic) or 2 (gated) cycles, never varying.
// - Only the interface style changes transmit latency, no other mode.
// - Receive adds a constant 6 plus 8 (classic) or 2 (gated) cycles after the buffer.
// - The tolerance buffer runs at 27 cycles nominal, within 24 to 34 under offset.
// - The tolerance buffer adds or drops cycles in steps of 2, at most 4 per frame.
// - Buffer thresholds default to 16 low and 32 high.
// - Latency is taken at the start delimiter edge, so slips happen only between frames.
// - Latencies count cycles of the datapath clock, measured with 12-cycle gaps.
module gbe_pcs_status_latency #(
  parameter gbe_pcs_pkg::gmii_style_t STYLE = gbe_pcs_pkg::GMII_CLASSIC,
  parameter int DATA_W   = 8,
  parameter int DEPTH    = `CTF_DEPTH,
  parameter int LOW_THR  = `CTF_LOW_THR,
  parameter int HIGH_THR = `CTF_HIGH_THR
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              sys_rst,
  // MAC transmit side
  input  wire logic [DATA_W-1:0] gmii_txd,
  input  wire logic              gmii_tx_en,
  input  wire logic              gmii_tx_er,
  // Transmit toward the line
  output wire logic [DATA_W-1:0] tx_code_data,
  output wire logic              tx_code_en,
  output wire logic              tx_code_er,
  // Receive from the line
  input  wire logic              rx_code_valid,
  input  wire logic [DATA_W-1:0] rx_code_data,
  input  wire logic              rx_code_dv,
  input  wire logic              rx_code_er,
  // MAC receive side
  output wire logic [DATA_W-1:0] gmii_rxd,
  output wire logic              gmii_rx_dv,
  output wire logic              gmii_rx_er,
  // Status toward the MAC
  output logic                   col,
  output logic                   crs
);
  import gbe_pcs_pkg::*;

  localparam int WORD_W = DATA_W + 2;
  localparam int DV_BIT = DATA_W;
  localparam int ER_BIT = DATA_W + 1;
  // Style alone selects the rate stage; no other mode enters here
  localparam int TX_LAT = `TX_FSM_LAT +
    ((STYLE == GMII_GATED) ? `TX_RA_LAT_GATED : `TX_RA_LAT_CLASSIC);
  localparam int RX_K = `RX_FSM_LAT +
    ((STYLE == GMII_GATED) ? `RX_RA_LAT_GATED : `RX_RA_LAT_CLASSIC);
  localparam int AW = $clog2(DEPTH);
  localparam int LW = AW + 1;
  localparam logic [LW-1:0] FULL_LVL  = LW'(DEPTH);
  localparam logic [LW-1:0] LOW_LVL   = LW'(LOW_THR);
  localparam logic [LW-1:0] HIGH_LVL  = LW'(HIGH_THR);
  // Two cycles pass between reaching this level and the first word out
  localparam logic [LW-1:0] START_LVL = LW'(`CTF_NOM_LAT - 2);
  localparam logic [3:0] SLIP_STEP  = 4'(`CTF_SLIP_STEP);
  localparam logic [3:0] SLIP_ROOM  = 4'(`CTF_SLIP_MAX - `CTF_SLIP_STEP);
  localparam logic [1:0] SLIP_EXTRA = 2'(`CTF_SLIP_STEP - 1);

  function automatic logic [LW-1:0] ptr_gap(input logic [LW-1:0] a, input logic [LW-1:0] b);
    return a - b;
  endfunction

  function automatic logic rising(input logic cur, input logic prev);
    return cur & ~prev;
  endfunction

  logic [WORD_W-1:0] tx_pipe_q [TX_LAT];
  logic [WORD_W-1:0] tx_pipe_d [TX_LAT];
  logic [WORD_W-1:0] rx_pipe_q [RX_K];
  logic [WORD_W-1:0] rx_pipe_d [RX_K];
  logic              col_d;
  logic              crs_d;
  ctf_state_t        state_q;
  ctf_state_t        state_d;
  logic [LW-1:0]     wr_ptr_q;
  logic [LW-1:0]     wr_ptr_d;
  logic [LW-1:0]     rd_ptr_q;
  logic [LW-1:0]     rd_ptr_d;
  logic [LW-1:0]     fill;
  logic [1:0]        add_cnt_q;
  logic [1:0]        add_cnt_d;
  logic [1:0]        drop_run_q;
  logic [1:0]        drop_run_d;
  logic [3:0]        add_used_q;
  logic [3:0]        add_used_d;
  logic [3:0]        drop_used_q;
  logic [3:0]        drop_used_d;
  logic              in_dv_q;
  logic              in_dv_d;
  logic              rvalid_q;
  logic              rvalid_d;
  logic              pop;
  logic              wr_en;
  logic              in_gap;
  logic              start_drop;
  logic              drop_now;
  logic              start_add;
  logic              out_frame_start;
  logic [WORD_W-1:0] rd_word;
  logic [WORD_W-1:0] ctf_word;

  // Transmit delay line, one flop per cycle, frame content ignored
  always_comb begin
    tx_pipe_d[0] = {gmii_tx_er, gmii_tx_en, gmii_txd};
    for (int i = 1; i < TX_LAT; i++) begin
      tx_pipe_d[i] = tx_pipe_q[i-1];
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < TX_LAT; i++) begin
        tx_pipe_q[i] <= '0;
      end
    end else begin
      tx_pipe_q <= tx_pipe_d;
    end
  end

  assign tx_code_data = tx_pipe_q[TX_LAT-1][DATA_W-1:0];
  assign tx_code_en   = tx_pipe_q[TX_LAT-1][DV_BIT];
  assign tx_code_er   = tx_pipe_q[TX_LAT-1][ER_BIT];

  // Tolerance buffer storage
  clock_tolerance_ram #(
    .WIDTH (WORD_W),
    .AW    (AW)
  ) u_ram (
    .clk     (clk),
    .sys_rst (sys_rst),
    .wr_en   (wr_en),
    .wr_addr (wr_ptr_q[AW-1:0]),
    .wr_data ({rx_code_er, rx_code_dv, rx_code_data}),
    .rd_en   (pop),
    .rd_addr (rd_ptr_q[AW-1:0]),
    .rd_data (rd_word)
  );

  // Tolerance buffer control: drops on the write side, adds on the read side
  always_comb begin
    ctf_word = rvalid_q ? rd_word : '0;
    fill = ptr_gap(wr_ptr_q, rd_ptr_q);
    // Slips only touch idle words between frames, so the delimiter edge never moves
    in_gap = ~rx_code_dv & ~in_dv_q;
    start_drop = rx_code_valid & in_gap & (state_q != CTF_FILL) & (fill > HIGH_LVL)
                 & (drop_run_q == 2'h0) & (drop_used_q <= SLIP_ROOM);
    drop_now = rx_code_valid & in_gap & ((drop_run_q != 2'h0) | start_drop);
    // A full buffer loses the word rather than wrapping onto unread data
    wr_en = rx_code_valid & ~drop_now & (fill != FULL_LVL);
    drop_run_d = drop_run_q;
    drop_used_d = drop_used_q;
    in_dv_d = in_dv_q;
    if (rx_code_valid) begin
      in_dv_d = rx_code_dv;
      if (!in_gap) begin
        drop_run_d = 2'h0;
      end else if (start_drop) begin
        drop_run_d = SLIP_EXTRA;
      end else if (drop_run_q != 2'h0) begin
        drop_run_d = drop_run_q - 2'h1;
      end
      if (start_drop) begin
        drop_used_d = drop_used_q + SLIP_STEP;
      end
      if (rising(rx_code_dv, in_dv_q)) begin
        drop_used_d = 4'h0;
      end
    end
    wr_ptr_d = wr_ptr_q + LW'(wr_en);

    out_frame_start = rising(ctf_word[DV_BIT], rx_pipe_q[0][DV_BIT]);
    start_add = (state_q == CTF_RUN) & ~ctf_word[DV_BIT] & (fill < LOW_LVL)
                & (add_used_q <= SLIP_ROOM);
    pop = 1'b0;
    state_d = state_q;
    add_cnt_d = add_cnt_q;
    add_used_d = add_used_q;
    if (out_frame_start) begin
      add_used_d = 4'h0;
    end
    unique case (state_q)
      CTF_FILL: begin
        if (fill >= START_LVL) begin
          state_d = CTF_RUN;
        end
      end
      CTF_RUN: begin
        if (start_add) begin
          state_d = CTF_ADD;
          add_cnt_d = SLIP_EXTRA;
          add_used_d = add_used_q + SLIP_STEP;
        end else begin
          pop = (fill != '0);
        end
      end
      CTF_ADD: begin
        add_cnt_d = add_cnt_q - 2'h1;
        if (add_cnt_q == 2'h1) begin
          state_d = CTF_RUN;
        end
      end
      default: begin
        state_d = CTF_FILL;
      end
    endcase
    rd_ptr_d = rd_ptr_q + LW'(pop);
    rvalid_d = pop;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q     <= CTF_FILL;
      wr_ptr_q    <= '0;
      rd_ptr_q    <= '0;
      add_cnt_q   <= 2'h0;
      drop_run_q  <= 2'h0;
      add_used_q  <= 4'h0;
      drop_used_q <= 4'h0;
      in_dv_q     <= 1'b0;
      rvalid_q    <= 1'b0;
    end else begin
      state_q     <= state_d;
      wr_ptr_q    <= wr_ptr_d;
      rd_ptr_q    <= rd_ptr_d;
      add_cnt_q   <= add_cnt_d;
      drop_run_q  <= drop_run_d;
      add_used_q  <= add_used_d;
      drop_used_q <= drop_used_d;
      in_dv_q     <= in_dv_d;
      rvalid_q    <= rvalid_d;
    end
  end

  // Receive state machine and rate stage as a fixed delay line, plus status
  always_comb begin
    rx_pipe_d[0] = ctf_word;
    for (int i = 1; i < RX_K; i++) begin
      rx_pipe_d[i] = rx_pipe_q[i-1];
    end
    // Built from next values so both status flops line up with the rx outputs
    col_d = gmii_tx_en & rx_pipe_d[RX_K-1][DV_BIT];
    crs_d = rx_pipe_d[RX_K-1][DV_BIT];
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < RX_K; i++) begin
        rx_pipe_q[i] <= '0;
      end
      col <= 1'b0;
      crs <= 1'b0;
    end else begin
      rx_pipe_q <= rx_pipe_d;
      col       <= col_d;
      crs       <= crs_d;
    end
  end

  assign gmii_rxd   = rx_pipe_q[RX_K-1][DATA_W-1:0];
  assign gmii_rx_dv = rx_pipe_q[RX_K-1][DV_BIT];
  assign gmii_rx_er = rx_pipe_q[RX_K-1][ER_BIT];

  // Cycles since reset, so history checks skip the reset period
  logic [5:0] age_q;
  logic [5:0] age_d;

  always_comb begin
    age_d = (age_q == 6'h3F) ? age_q : age_q + 6'h01;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      age_q <= 6'h00;
    end else begin
      age_q <= age_d;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  col_and_a: assert property ((age_q != 6'h00) |->
    (col == ($past(gmii_tx_en) & gmii_rx_dv)))
    else $error("collision is not tx enable and rx valid");
  crs_track_a: assert property ((crs == gmii_rx_dv) &&
    (!crs || $past(rx_pipe_q[RX_K-2][DV_BIT])))
    else $error("carrier sense differs from rx valid");
  tx_delay_a: assert property ((age_q > 6'(TX_LAT)) |->
    ({tx_code_er, tx_code_en, tx_code_data} ==
     $past({gmii_tx_er, gmii_tx_en, gmii_txd}, TX_LAT)))
    else $error("transmit latency wrong");
  rx_delay_a: assert property ((age_q > 6'(RX_K)) |->
    ({gmii_rx_er, gmii_rx_dv, gmii_rxd} == $past(ctf_word, RX_K)))
    else $error("receive fixed latency wrong");
  ctf_start_a: assert property ((state_q == CTF_FILL && state_d == CTF_RUN) |->
    (fill == START_LVL) ##1 pop ##1 rvalid_q)
    else $error("buffer started at wrong fill");
  add_step_a: assert property ((state_q == CTF_RUN && state_d == CTF_ADD) |->
    !pop ##1 (state_q == CTF_ADD && !pop) ##1 (state_q == CTF_RUN))
    else $error("added slip is not two cycles");
  slip_budget_a: assert property ((add_used_q <= 4'(`CTF_SLIP_MAX)) &&
    (drop_used_q <= 4'(`CTF_SLIP_MAX)))
    else $error("more than four slips in a frame");
  add_thresh_a: assert property (start_add |-> (fill < LOW_LVL) && !ctf_word[DV_BIT])
    else $error("slip added above low threshold");
  drop_thresh_a: assert property (start_drop |->
    (fill > HIGH_LVL) ##1 (drop_run_q == 2'h1))
    else $error("slip dropped below high threshold");
  gap_only_a: assert property (drop_now |-> !rx_code_dv && !in_dv_q && !wr_en)
    else $error("frame word dropped");

  add_seen_c: cover property (state_q == CTF_RUN ##1 state_q == CTF_ADD);
  drop_seen_c: cover property (start_drop ##1 drop_now);
  col_seen_c: cover property (col);
  frame_out_c: cover property (!gmii_rx_dv ##1 gmii_rx_dv);

endmodule

`default_nettype wire

// ---- bench/mac_model.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "gbe_pcs_map.svh"
module mac_model (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // Frame request
  input  wire logic       go,
  input  wire logic [7:0] len,
  output logic            busy,
  // Frame output
  output logic      [7:0] txd,
  output logic            tx_en,
  output logic            tx_er
);
  int pos;
  int tot;
  int plen;

  // Busy until the trailing gap has run out
  assign busy = pos < tot;

  // Preamble, start delimiter, payload, then a fixed gap
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pos <= 0;
      tot <= 0;
      plen <= 0;
      txd <= 8'h00;
      tx_en <= 1'b0;
      tx_er <= 1'b0;
    end else if (go && !busy) begin
      pos <= 0;
      plen <= int'(len);
      tot <= 8 + int'(len) + `MEAS_IFG_CYCLES;
    end else if (busy && pos < 8 + plen) begin
      pos <= pos + 1;
      tx_en <= 1'b1;
      txd <= (pos < 7) ? 8'h55 : (pos == 7) ? 8'hD5 : 8'($urandom);
      tx_er <= (pos > 7) && ($urandom % 16 == 0);
    end else begin
      // Idle line toggles so a stale byte never passes for data
      if (busy) begin
        pos <= pos + 1;
      end
      tx_en <= 1'b0;
      tx_er <= 1'b0;
      txd <= ~txd;
    end
  end
endmodule
`default_nettype wire

// ---- bench/tb_gbe_pcs_status_latency.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "gbe_pcs_map.svh"
module tb_gbe_pcs_status_latency;
  typedef struct {int cyc; logic [7:0] d; logic er; bit ex; bit lz;} note_t;
  logic       clk = 1'b0;
  logic       sys_rst = 1'b1;
  logic       go = 1'b0;
  logic [7:0] len = 8'h01;
  logic       rx_code_valid = 1'b1;
  logic [7:0] gmii_txd, rx_code_data;
  logic       gmii_tx_en, gmii_tx_er, rx_code_dv, rx_code_er;
  logic       busy_t, busy_r;
  logic       tx_prev = 1'b0;
  bit         exact_q = 1'b1;
  bit         loose_q = 1'b0;
  int         cyc = 0;
  int         miscompares = 0;
  int         n_checks = 0;
  logic [7:0] tcd [2];
  logic [7:0] rxd [2];
  logic       tce [2], tcer [2], rdv [2], rer [2], col_o [2], crs_o [2];
  note_t      txq [2][$];
  note_t      rxq [2][$];

  // Free-running clock, 50 ns
  initial begin
    forever #25 clk = ~clk;
  end

  // Cycle count and previous transmit enable
  always @(posedge clk) begin
    cyc <= cyc + 1;
    tx_prev <= gmii_tx_en;
  end

  // MAC on the transmit side, frame source on the line side
  mac_model i_mac (.clk(clk), .sys_rst(sys_rst), .go(go), .len(len), .busy(busy_t),
    .txd(gmii_txd), .tx_en(gmii_tx_en), .tx_er(gmii_tx_er));
  mac_model i_line (.clk(clk), .sys_rst(sys_rst), .go(go), .len(len), .busy(busy_r),
    .txd(rx_code_data), .tx_en(rx_code_dv), .tx_er(rx_code_er));

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic chk_rng(input string what, input int lo, input int hi, input int got);
    n_checks++;
    if (got < lo || got > hi) begin
      miscompares++;
      $display("BAD %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask

  // Words still waiting for their output, all paths and both instances
  function automatic int left();
    return rxq[0].size() + rxq[1].size() + txq[0].size() + txq[1].size();
  endfunction

  // Bounded wait until every noted word has come out
  task automatic drain();
    for (int w = 0; w < 200 && left() > 0; w++) begin
      @(posedge clk);
    end
    chk("words_left", 0, left());
    if (left() != 0) begin
      results();
    end
  endtask

  // Classic and gated instances see the same traffic
  for (genvar k = 0; k < 2; k++) begin : g_dut
    localparam int TXL = `TX_FSM_LAT + (k ? `TX_RA_LAT_GATED : `TX_RA_LAT_CLASSIC);
    localparam int RXK = `RX_FSM_LAT + (k ? `RX_RA_LAT_GATED : `RX_RA_LAT_CLASSIC);
    // Twelve line words never written, then at most four added back
    localparam int SLO = `CTF_NOM_LAT - 12 + RXK;
    localparam int SHI = SLO + `CTF_SLIP_MAX;
    note_t n;
    gbe_pcs_status_latency #(
      .STYLE(k ? gbe_pcs_pkg::GMII_GATED : gbe_pcs_pkg::GMII_CLASSIC)
    ) i_dut (
      .clk(clk), .sys_rst(sys_rst), .gmii_txd(gmii_txd), .gmii_tx_en(gmii_tx_en),
      .gmii_tx_er(gmii_tx_er), .tx_code_data(tcd[k]), .tx_code_en(tce[k]),
      .tx_code_er(tcer[k]), .rx_code_valid(rx_code_valid), .rx_code_data(rx_code_data),
      .rx_code_dv(rx_code_dv), .rx_code_er(rx_code_er), .gmii_rxd(rxd[k]),
      .gmii_rx_dv(rdv[k]), .gmii_rx_er(rer[k]), .col(col_o[k]), .crs(crs_o[k])
    );
    // Note each word as it is taken, compare as it leaves
    always @(posedge clk) begin
      if (!sys_rst) begin
        if (gmii_tx_en === 1'b1) begin
          txq[k].push_back('{cyc, gmii_txd, gmii_tx_er, 1'b1, 1'b0});
        end
        if (rx_code_valid && rx_code_dv === 1'b1) begin
          rxq[k].push_back('{cyc, rx_code_data, rx_code_er, exact_q, loose_q});
        end
        if (tce[k] === 1'b1) begin
          n = txq[k].size() ? txq[k].pop_front() : '{0, 8'h00, 1'bx, 1'b1, 1'b0};
          chk("tx_latency", n.cyc + TXL, cyc);
          chk("tx_word", {n.er, n.d}, {tcer[k], tcd[k]});
        end
        if (rdv[k] === 1'b1) begin
          n = rxq[k].size() ? rxq[k].pop_front() : '{0, 8'h00, 1'bx, 1'b1, 1'b0};
          if (n.lz) begin
            chk_rng("rx_latency", SLO, SHI, cyc - n.cyc);
          end else if (n.ex) begin
            chk("rx_latency", n.cyc + `CTF_NOM_LAT + RXK, cyc);
          end else begin
            chk_rng("rx_latency", `CTF_MIN_LAT + RXK, `CTF_MAX_LAT + RXK, cyc - n.cyc);
          end
          chk("rx_word", {n.er, n.d}, {rer[k], rxd[k]});
        end
        chk("crs", rdv[k], crs_o[k]);
        chk("col", tx_prev & rdv[k], col_o[k]);
      end
    end
  end

  // Start cnt frames on both sides, one at a time, waiting for each gap to end
  task automatic frames(input int cnt, input int lmax);
    int w;
    for (int i = 0; i < cnt; i++) begin
      @(posedge clk);
      len <= 8'($urandom_range(1, lmax));
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      #1;
      for (w = 0; w < 300 && (busy_t || busy_r); w++) begin
        @(posedge clk);
        #1;
      end
      if (w == 300) begin
        chk("frame_timeout", 0, 1);
        results();
      end
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    void'($urandom(32'h9FF6E5B6));
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    // Overlapping frames on both paths, fixed latency
    frames(4, 30);
    $display("test nominal done");
    // Shortest frames back to back
    frames(6, 1);
    $display("test back_to_back done");
    // Two missing line words in a gap shift the buffer latency
    @(posedge clk);
    rx_code_valid <= 1'b0;
    exact_q <= 1'b0;
    repeat (2) @(posedge clk);
    rx_code_valid <= 1'b1;
    frames(4, 20);
    $display("test line_stall done");
    // Long stall empties the buffer below its low threshold, so idle cycles get added
    drain();
    @(posedge clk);
    rx_code_valid <= 1'b0;
    loose_q <= 1'b1;
    repeat (10) @(posedge clk);
    rx_code_valid <= 1'b1;
    frames(2, 20);
    drain();
    $display("test add_slip done");
    // Reset in mid-run brings the buffer back to its nominal fill
    sys_rst <= 1'b1;
    loose_q <= 1'b0;
    exact_q <= 1'b1;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    frames(2, 30);
    drain();
    $display("test reset_rerun done");
    results();
  end
endmodule
`default_nettype wire
